/* verilog/oaf_pkg.sv */
`default_nettype none
package oaf_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_US = 1000;
    localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);
    localparam logic [9:0] MS_LAST = 10'(MS_US - 1);

    // frame codes
    localparam logic [3:0] FRAME_TYPE_OPEN = 4'h1;
    localparam logic [3:0] FEATURES_VAL = 4'h0;
    localparam logic [2:0] PROTO_SMP = 3'h0;
    localparam logic [2:0] PROTO_SSP = 3'h1;
    localparam logic [2:0] PROTO_STP = 3'h2;
    localparam logic [3:0] RATE_1G5 = 4'h8;
    localparam logic [3:0] RATE_3G0 = 4'h9;
    localparam logic [15:0] TAG_NONE = 16'hFFFF;
    localparam logic [7:0] PBC_MAX = 8'hFF;
    localparam logic [15:0] WAIT_MAX = 16'hFFFF;
    localparam logic [15:0] WAIT_MS_BASE = 16'h8000;
    localparam logic [2:0] LAST_DWORD = 3'h7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TAG = 8'h04;
    localparam logic [7:0] REG_DST_LO = 8'h08;
    localparam logic [7:0] REG_DST_HI = 8'h0C;
    localparam logic [7:0] REG_SRC_LO = 8'h10;
    localparam logic [7:0] REG_SRC_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_WAIT = 8'h1C;
    localparam logic [7:0] REG_RX_HEAD = 8'h20;
    localparam logic [7:0] REG_RX_DST_LO = 8'h24;
    localparam logic [7:0] REG_RX_DST_HI = 8'h28;
    localparam logic [7:0] REG_RX_SRC_LO = 8'h2C;
    localparam logic [7:0] REG_RX_SRC_HI = 8'h30;
    localparam logic [7:0] REG_RX_ARB = 8'h34;
    localparam logic [7:0] REG_COUNT = 8'h38;

    // control field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_PROTO = 2;
    localparam int CTRL_NEWREQ = 5;
    localparam int CTRL_RETRY = 6;
    localparam int CTRL_RATE = 8;
    localparam int CTRL_TAGREQ = 12;
    localparam int CTRL_RATEREJ = 13;
    localparam int CTRL_WAITRUN = 14;

    // reset values
    localparam logic [3:0] RATE_RESET = RATE_1G5;
    localparam logic [15:0] TAG_RESET = TAG_NONE;

    typedef struct packed {
        logic initiator;
        logic [2:0] proto;
        logic [3:0] rate;
        logic [15:0] tag;
        logic [63:0] dst;
        logic [63:0] src;
        logic [7:0] pbc;
        logic [15:0] waitTime;
    } oaf_open_t;

    typedef struct packed {
        logic sof;
        logic eof;
        logic [31:0] data;
    } oaf_dw_t;
endpackage
`default_nettype wire

/* verilog/oaf_crc_step.sv */
`default_nettype none
module oaf_crc_step import oaf_pkg::*; (
    input wire logic [31:0] crcIn,
    input wire logic [31:0] dataIn,
    output logic [31:0] crcOut
);
    // one dword, msb first
    always_comb begin
        logic [31:0] c;
        c = crcIn;
        for (int i = 31; i >= 0; i--) begin
            if (c[31] ^ dataIn[i]) begin
                c = {c[30:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        crcOut = c;
    end
endmodule
`default_nettype wire

/* verilog/oaf_codec.sv */
`default_nettype none
module oaf_codec import oaf_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output oaf_dw_t txWord,
    output logic txValid,
    input wire logic txReady,
    input wire oaf_dw_t rxWord,
    input wire logic rxValid,
    output logic connInitiator,
    output logic rxFrameStrobe
);
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} oaf_tx_t;

    function automatic logic [31:0] openWord(oaf_open_t f, logic [2:0] i);
        case (i)
            3'h0: openWord = {f.initiator, f.proto, FRAME_TYPE_OPEN,
                FEATURES_VAL, f.rate, f.tag};
            3'h1: openWord = f.dst[63:32];
            3'h2: openWord = f.dst[31:0];
            3'h3: openWord = f.src[63:32];
            3'h4: openWord = f.src[31:0];
            3'h5: openWord = {8'h00, f.pbc, f.waitTime};
            default: openWord = 32'h00000000;
        endcase
    endfunction

    function automatic logic isMapped(logic [7:0] a);
        isMapped = (a[1:0] == 2'h0) && (a <= REG_COUNT);
    endfunction

    logic ctrlInit, ctrlTagReq, ctrlRateRej, waitRun;
    logic [2:0] ctrlProto;
    logic [3:0] ctrlRate;
    logic [15:0] tagVal;
    logic [63:0] dstAddr, srcAddr;
    logic [7:0] pbc;
    logic [15:0] waitCode;
    logic [7:0] usCnt;
    logic [9:0] msCnt;
    logic [3:0] lastRate;
    logic [15:0] lastTag;
    logic haveLast;
    oaf_tx_t txState;
    logic [2:0] txIdx;
    logic [31:0] txCrc, txCrcNext;
    oaf_open_t txFrame, next_txFrame;
    logic [3:0] rxCnt;
    logic [31:0] rxCrc, rxCrcIn, rxCrcNext;
    logic [31:0] rxBuf [0:6];
    oaf_open_t rxFrame;
    logic [7:0] rxOkCnt, rxDropCnt;
    logic acc, wrAcc, startReq, newReq, retryReq, usTick, rxGood;

    assign acc = psel & penable & pready;
    assign wrAcc = acc & pwrite;
    assign startReq = wrAcc && paddr == REG_CTRL && pwdata[CTRL_START]
                      && txState == TX_IDLE;
    assign newReq = wrAcc && paddr == REG_CTRL && pwdata[CTRL_NEWREQ];
    assign retryReq = wrAcc && paddr == REG_CTRL && pwdata[CTRL_RETRY];
    assign usTick = waitRun && usCnt == US_LAST;

    // apb answer: zero wait, data ready in access phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~isMapped(paddr);
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    REG_CTRL: prdata <= {17'h0, waitRun, ctrlRateRej,
                        ctrlTagReq, ctrlRate, 3'h0, ctrlProto, ctrlInit,
                        1'b0};
                    REG_TAG: prdata <= {16'h0, tagVal};
                    REG_DST_LO: prdata <= dstAddr[31:0];
                    REG_DST_HI: prdata <= dstAddr[63:32];
                    REG_SRC_LO: prdata <= srcAddr[31:0];
                    REG_SRC_HI: prdata <= srcAddr[63:32];
                    REG_STATUS: prdata <= {lastTag, lastRate, pbc[3:0],
                        5'h0, haveLast, connInitiator, txState};
                    REG_WAIT: prdata <= {8'h0, pbc, waitCode};
                    REG_RX_HEAD: prdata <= {rxFrame.initiator,
                        rxFrame.proto, FRAME_TYPE_OPEN, 4'h0,
                        rxFrame.rate, rxFrame.tag};
                    REG_RX_DST_LO: prdata <= rxFrame.dst[31:0];
                    REG_RX_DST_HI: prdata <= rxFrame.dst[63:32];
                    REG_RX_SRC_LO: prdata <= rxFrame.src[31:0];
                    REG_RX_SRC_HI: prdata <= rxFrame.src[63:32];
                    REG_RX_ARB: prdata <= {8'h0, rxFrame.pbc,
                        rxFrame.waitTime};
                    REG_COUNT: prdata <= {16'h0, rxDropCnt, rxOkCnt};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // software request setup
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrlInit <= 1'b0;
            ctrlProto <= PROTO_SSP;
            ctrlRate <= RATE_RESET;
            ctrlTagReq <= 1'b0;
            ctrlRateRej <= 1'b0;
            waitRun <= 1'b0;
            tagVal <= TAG_RESET;
            dstAddr <= 64'h0;
            srcAddr <= 64'h0;
        end else if (wrAcc) begin
            case (paddr)
                REG_CTRL: begin
                    ctrlInit <= pwdata[CTRL_INIT];
                    ctrlProto <= pwdata[CTRL_PROTO +: 3];
                    ctrlRate <= pwdata[CTRL_RATE +: 4];
                    ctrlTagReq <= pwdata[CTRL_TAGREQ];
                    ctrlRateRej <= pwdata[CTRL_RATEREJ];
                    waitRun <= pwdata[CTRL_WAITRUN];
                end
                REG_TAG: tagVal <= pwdata[15:0];
                REG_DST_LO: dstAddr[31:0] <= pwdata;
                REG_DST_HI: dstAddr[63:32] <= pwdata;
                REG_SRC_LO: srcAddr[31:0] <= pwdata;
                REG_SRC_HI: srcAddr[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // blocked retry count
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pbc <= 8'h00;
        end else if (newReq) begin
            pbc <= 8'h00;
        end else if (retryReq && pbc != PBC_MAX) begin
            pbc <= pbc + 8'h01;
        end
    end

    // arbitration wait time
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            usCnt <= 8'h00;
            msCnt <= 10'h000;
            waitCode <= 16'h0000;
        end else if (newReq) begin
            usCnt <= 8'h00;
            msCnt <= 10'h000;
            waitCode <= 16'h0000;
        end else if (waitRun) begin
            usCnt <= usTick ? 8'h00 : usCnt + 8'h01;
            if (usTick) begin
                if (waitCode < WAIT_MS_BASE) begin
                    waitCode <= waitCode + 16'h0001;
                end else if (msCnt == MS_LAST) begin
                    msCnt <= 10'h000;
                    if (waitCode != WAIT_MAX) begin
                        waitCode <= waitCode + 16'h0001;
                    end
                end else begin
                    msCnt <= msCnt + 10'h001;
                end
            end
        end
    end

    // choose rate and tag for the outgoing request
    always_comb begin
        next_txFrame.initiator = ctrlInit;
        next_txFrame.proto = ctrlProto;
        next_txFrame.dst = dstAddr;
        next_txFrame.src = srcAddr;
        next_txFrame.pbc = pbc;
        next_txFrame.waitTime = waitCode;
        if (ctrlInit) begin
            next_txFrame.rate = ctrlRate;
            if (ctrlProto == PROTO_SMP || !ctrlTagReq) begin
                next_txFrame.tag = TAG_NONE;
            end else begin
                next_txFrame.tag = tagVal;
            end
        end else begin
            // target keeps the initiator's rate unless none was received or rate reject is set; then it sends its own
            if (haveLast && !ctrlRateRej) begin
                next_txFrame.rate = lastRate;
            end else begin
                next_txFrame.rate = ctrlRate;
            end
            next_txFrame.tag = lastTag;
        end
    end

    oaf_crc_step txCrcStep (
        .crcIn(txCrc),
        .dataIn(txWord.data),
        .crcOut(txCrcNext)
    );

    // transmit framer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txState <= TX_IDLE;
            txIdx <= 3'h0;
            txValid <= 1'b0;
            txWord <= '0;
            txCrc <= CRC_INIT;
            txFrame <= '0;
        end else begin
            case (txState)
                TX_IDLE: begin
                    if (startReq) begin
                        txFrame <= next_txFrame;
                        txIdx <= 3'h0;
                        txCrc <= CRC_INIT;
                        txValid <= 1'b1;
                        txWord <= '{sof: 1'b1, eof: 1'b0,
                            data: openWord(next_txFrame, 3'h0)};
                        txState <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (txReady) begin
                        if (txIdx == LAST_DWORD) begin
                            txValid <= 1'b0;
                            txWord <= '0;
                            txState <= TX_IDLE;
                        end else begin
                            txIdx <= txIdx + 3'h1;
                            txCrc <= txCrcNext;
                            txWord.sof <= 1'b0;
                            txWord.eof <= (txIdx + 3'h1) == LAST_DWORD;
                            if ((txIdx + 3'h1) == LAST_DWORD) begin
                                txWord.data <= txCrcNext;
                            end else begin
                                txWord.data <= openWord(txFrame,
                                    txIdx + 3'h1);
                            end
                        end
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    // receive checker
    assign rxCrcIn = rxWord.sof ? CRC_INIT : rxCrc;

    oaf_crc_step rxCrcStep (
        .crcIn(rxCrcIn),
        .dataIn(rxWord.data),
        .crcOut(rxCrcNext)
    );

    assign rxGood = !rxWord.sof && rxCnt == 4'h7
                    && rxBuf[0][27:24] == FRAME_TYPE_OPEN
                    && rxWord.data == rxCrc;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rxCnt <= 4'h8;
            rxCrc <= CRC_INIT;
        end else if (rxValid) begin
            if (rxWord.sof) begin
                rxCnt <= 4'h1;
                rxCrc <= rxCrcNext;
            end else if (rxWord.eof) begin
                rxCnt <= 4'h8;
            end else if (rxCnt != 4'h8) begin
                rxCnt <= rxCnt + 4'h1;
                rxCrc <= rxCrcNext;
            end
        end
    end

    generate
        for (genvar g = 0; g < 7; g++) begin : gRxBuf
            always_ff @(posedge sys_clk) begin
                if (rxValid && !rxWord.eof
                    && (rxWord.sof ? g == 0 : rxCnt == 4'(g))) begin
                    rxBuf[g] <= rxWord.data;
                end
            end
        end
    endgenerate

    // accepted frame: decode, remember, count; others only counted
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rxFrame <= '0;
            rxOkCnt <= 8'h00;
            rxDropCnt <= 8'h00;
            rxFrameStrobe <= 1'b0;
            lastRate <= RATE_RESET;
            lastTag <= TAG_RESET;
            haveLast <= 1'b0;
        end else begin
            rxFrameStrobe <= rxValid && rxWord.eof && rxGood;
            if (rxValid && rxWord.eof) begin
                if (rxGood) begin
                    rxOkCnt <= rxOkCnt + 8'h01;
                    rxFrame.initiator <= rxBuf[0][31];
                    rxFrame.proto <= rxBuf[0][30:28];
                    rxFrame.rate <= rxBuf[0][19:16];
                    rxFrame.tag <= rxBuf[0][15:0];
                    rxFrame.dst <= {rxBuf[1], rxBuf[2]};
                    rxFrame.src <= {rxBuf[3], rxBuf[4]};
                    rxFrame.pbc <= rxBuf[5][23:16];
                    rxFrame.waitTime <= rxBuf[5][15:0];
                    // tag kept without consistency check
                    if (rxBuf[0][31] && (rxBuf[0][30:28] == PROTO_SSP
                        || rxBuf[0][30:28] == PROTO_STP)) begin
                        lastRate <= rxBuf[0][19:16];
                        lastTag <= rxBuf[0][15:0];
                        haveLast <= 1'b1;
                    end
                end else begin
                    rxDropCnt <= rxDropCnt + 8'h01;
                end
            end
        end
    end

    // role held for the connection
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            connInitiator <= 1'b0;
        end else if (startReq) begin
            connInitiator <= ctrlInit;
        end else if (rxValid && rxWord.eof && rxGood) begin
            connInitiator <= ~rxBuf[0][31];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence sStart;
        startReq;
    endsequence
    sequence sSofOut;
        txValid && txWord.sof && txIdx == 3'h0;
    endsequence

    a_start_sof: assert property (sStart |=> sSofOut)
        else $error("start did not produce a first dword");
    a_type_feat: assert property (txValid && txWord.sof |->
        txWord.data[27:24] == FRAME_TYPE_OPEN
        && txWord.data[23:20] == FEATURES_VAL)
        else $error("bad type or features nibble");
    a_smp_tag: assert property (txValid && txWord.sof && txWord.data[31]
        && txWord.data[30:28] == PROTO_SMP |->
        txWord.data[15:0] == TAG_NONE)
        else $error("smp initiator tag not all ones");
    a_byte20_zero: assert property (txValid && txIdx == 3'h5 |->
        txWord.data[31:24] == 8'h00)
        else $error("byte 20 not zero");
    a_tail_zero: assert property (txValid && txIdx == 3'h6 |->
        txWord.data == 32'h00000000)
        else $error("bytes 24 to 27 not zero");
    a_frame_len: assert property (txValid && txWord.eof |->
        txIdx == LAST_DWORD)
        else $error("frame length not eight dwords");
    a_pbc_sat: assert property (pbc == PBC_MAX && !newReq |=>
        pbc == PBC_MAX)
        else $error("retry count wrapped");
    a_pbc_clear: assert property (newReq |=> pbc == 8'h00)
        else $error("retry count not cleared");
    a_wait_us: assert property (usTick && !newReq
        && waitCode < WAIT_MS_BASE |=>
        waitCode == $past(waitCode) + 16'h0001)
        else $error("microsecond step missed");
    a_wait_sat: assert property (waitCode == WAIT_MAX && !newReq |=>
        waitCode == WAIT_MAX)
        else $error("wait time rolled over");
    a_role_tx: assert property (startReq |=>
        connInitiator == $past(ctrlInit))
        else $error("role not kept after send");
    a_drop_bad: assert property (rxValid && rxWord.eof && !rxGood |=>
        !rxFrameStrobe && rxDropCnt == $past(rxDropCnt) + 8'h01)
        else $error("bad frame accepted");
endmodule
`default_nettype wire

/* dv/oaf_peer.sv */
`default_nettype none
module oaf_peer import oaf_pkg::*; (
    input wire logic sys_clk,
    input wire oaf_dw_t txWord,
    input wire logic txValid,
    output logic txReady,
    output oaf_dw_t rxWord,
    output logic rxValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b0;
    logic crcOk;
    int nFrames = 0;
    int idx = 0;
    logic [31:0] got [8];
    logic [31:0] crc;
    function automatic logic [31:0] crc_add(logic [31:0] c, logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
        end
        return c;
    endfunction
    initial begin
        txReady = 1'b0;
        rxValid = 1'b0;
        rxWord = '0;
    end
    // takes dwords, stalling every other cycle when asked
    always @(posedge sys_clk) begin
        txReady <= stall ? ~txReady : 1'b1;
        if (txValid && txReady) begin
            if (txWord.sof) begin
                idx = 0;
                crc = CRC_INIT;
            end
            got[idx[2:0]] = txWord.data;
            if (idx < 7) crc = crc_add(crc, txWord.data);
            if (txWord.eof) begin
                crcOk = (crc === txWord.data);
                nFrames++;
            end
            idx++;
        end
    end
    // sends seven dwords then checksum, optionally corrupted
    task automatic send(input logic [223:0] f, input logic bad);
        logic [31:0] c;
        c = CRC_INIT;
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            rxValid <= 1'b1;
            rxWord.sof <= (k == 0);
            rxWord.eof <= (k == 7);
            if (k < 7) begin
                rxWord.data <= f[223 - 32 * k -: 32];
                c = crc_add(c, f[223 - 32 * k -: 32]);
            end else begin
                rxWord.data <= c ^ {31'h0, bad};
            end
        end
        @(posedge sys_clk);
        rxValid <= 1'b0;
        rxWord <= ~rxWord;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t mismatch %0h vs %0h", $time, (g), (e)); end end
module tb_top import oaf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv, c, e;
    logic pready, pslverr, txValid, txReady, rxValid, connInitiator;
    logic rxFrameStrobe, lastErr;
    oaf_dw_t txWord, rxWord;
    int n_errors = 0, n_checks = 0, nStrobe = 0;
    oaf_codec oaf_codec_i (.sys_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .txWord, .txValid,
        .txReady, .rxWord, .rxValid, .connInitiator, .rxFrameStrobe);
    oaf_peer oaf_peer_i (.sys_clk, .txWord, .txValid, .txReady, .rxWord,
        .rxValid);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (rxFrameStrobe === 1'b1) nStrobe++;
    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            finish_test();
        end
        rdv = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic frame(input logic [31:0] cw);
        int n0, n;
        n0 = oaf_peer_i.nFrames;
        apb(1'b1, REG_CTRL, cw);
        apb(1'b1, REG_CTRL, cw | 32'h1);
        n = 0;
        while (oaf_peer_i.nFrames == n0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 100) begin
            n_errors++;
            finish_test();
        end
    endtask
    function automatic logic [31:0] ctl(logic i, logic [2:0] p, logic [3:0] r,
        logic [31:0] x);
        return 32'(i) << CTRL_INIT | 32'(p) << CTRL_PROTO
            | 32'(r) << CTRL_RATE | x;
    endfunction
    function automatic logic [31:0] dw0(logic i, logic [2:0] p, logic [3:0] r,
        logic [15:0] t);
        return {i, p, 4'h1, 4'h0, r, t};
    endfunction
    function automatic logic [63:0] pair(int k);
        return {oaf_peer_i.got[k], oaf_peer_i.got[k + 1]};
    endfunction
    initial begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        apb(1'b0, REG_TAG, 32'h0);
        `CHK(rdv[15:0], 16'hFFFF)
        apb(1'b0, 8'h3C, 32'h0);
        `CHK({lastErr, rdv}, 33'h100000000)
        apb(1'b1, REG_DST_LO, 32'h89ABCDEF);
        apb(1'b1, REG_DST_HI, 32'h01234567);
        apb(1'b1, REG_SRC_LO, 32'h76543210);
        apb(1'b1, REG_SRC_HI, 32'hFEDCBA98);
        apb(1'b1, REG_TAG, 32'h5A5A);
        c = ctl(1'b1, PROTO_SSP, RATE_3G0, 32'h0);
        apb(1'b1, REG_CTRL, c | 32'h20);
        repeat (2) apb(1'b1, REG_CTRL, c | 32'h40);
        oaf_peer_i.stall <= 1'b1;
        frame(c);
        e = dw0(1'b1, PROTO_SSP, RATE_3G0, 16'hFFFF);
        `CHK(oaf_peer_i.got[0], e)
        `CHK(pair(1), 64'h0123456789ABCDEF)
        `CHK(pair(3), 64'hFEDCBA9876543210)
        `CHK(pair(5), 64'h0002000000000000)
        `CHK(oaf_peer_i.crcOk, 1'b1)
        `CHK(connInitiator, 1'b1)
        repeat (256) apb(1'b1, REG_CTRL, c | 32'h40);
        frame(c);
        `CHK(oaf_peer_i.got[5][23:16], 8'hFF)
        apb(1'b1, REG_CTRL, c | 32'h60);
        apb(1'b0, REG_WAIT, 32'h0);
        `CHK(rdv[23:16], 8'h00)
        apb(1'b1, REG_CTRL, c | 32'h4020);
        repeat (900) @(posedge sys_clk);
        apb(1'b0, REG_WAIT, 32'h0);
        `CHK(rdv[15:0], 16'h0003)
        oaf_peer_i.stall <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            frame(ctl(1'b1, 3'(p), RATE_1G5, 32'h1000));
            e = dw0(1'b1, 3'(p), RATE_1G5, p == 0 ? 16'hFFFF : 16'h5A5A);
            `CHK(oaf_peer_i.got[0], e)
        end
        e = dw0(1'b1, PROTO_SSP, RATE_1G5, 16'h1234);
        oaf_peer_i.send({e, 128'h0, 64'hAB00000055AA55AA}, 1'b0);
        repeat (2) @(posedge sys_clk);
        `CHK(nStrobe, 1)
        `CHK(connInitiator, 1'b0)
        frame(ctl(1'b0, PROTO_SSP, RATE_3G0, 32'h0));
        e = dw0(1'b0, PROTO_SSP, RATE_1G5, 16'h1234);
        `CHK(oaf_peer_i.got[0], e)
        frame(ctl(1'b0, PROTO_STP, RATE_3G0, 32'h0));
        e = dw0(1'b0, PROTO_STP, RATE_1G5, 16'h1234);
        `CHK(oaf_peer_i.got[0], e)
        frame(ctl(1'b0, PROTO_STP, RATE_3G0, 32'h2000));
        e = dw0(1'b0, PROTO_STP, RATE_3G0, 16'h1234);
        `CHK(oaf_peer_i.got[0], e)
        e = dw0(1'b1, PROTO_SSP, RATE_1G5, 16'h1234);
        oaf_peer_i.send({e, 192'h0}, 1'b1);
        oaf_peer_i.send({e ^ 32'h01000000, 192'h0}, 1'b0);
        repeat (2) @(posedge sys_clk);
        `CHK(nStrobe, 1)
        apb(1'b0, REG_COUNT, 32'h0);
        `CHK(rdv[15:0], 16'h0201)
        finish_test();
    end
endmodule
`default_nettype wire
